//--- hdl/ccg_pkg.sv
// Purpose: Constants for the current channel gain control block.
// Assumes: One system clock at 100 MHz, asynchronous active-high reset.
// Notes:   Register indices are word indices on the plain register port.
package ccg_pkg;
    // -----------------------------------------------------------------
    // Register indices
    // -----------------------------------------------------------------
    localparam logic [3:0] CCG_REG_THRESH  = 4'h0;
    localparam logic [3:0] CCG_REG_GAIN    = 4'h1;
    localparam logic [3:0] CCG_REG_CTRL    = 4'h2;
    localparam logic [3:0] CCG_REG_STATUS  = 4'h3;
    localparam logic [3:0] CCG_REG_MASK    = 4'h4;
    localparam logic [3:0] CCG_REG_OFFSET  = 4'h5;
    localparam logic [3:0] CCG_REG_CUR_RES = 4'h6;
    localparam logic [3:0] CCG_REG_VLT_RES = 4'h7;
    localparam logic [3:0] CCG_REG_TMP_RES = 4'h8;
    // -----------------------------------------------------------------
    // Field positions and reset values
    // -----------------------------------------------------------------
    localparam int CCG_CTRL_AUTO_BIT  = 0;
    localparam int CCG_CTRL_SENSE_BIT = 1;
    localparam int CCG_CTRL_AUX_BIT   = 2;
    localparam int CCG_CTRL_ETMP_BIT  = 3;
    localparam int CCG_ST_GAIN_BIT    = 0;
    localparam int CCG_ST_OPEN_BIT    = 1;
    localparam int CCG_ST_RES_BIT     = 2;
    localparam logic [7:0] CCG_THRESH_RST = 8'hf0;
    localparam logic [2:0] CCG_GAIN_RST   = 3'h0;
    localparam logic [3:0] CCG_CTRL_RST   = 4'h1;
    localparam logic [2:0] CCG_GAIN_MAX   = 3'h7;
    localparam logic [2:0] CCG_GAIN_MIN   = 3'h0;
    // Auto gain engine states.
    typedef enum logic [1:0] {
        CCG_IDLE = 2'b01,
        CCG_HOLD = 2'b10
    } ccg_state_type;
endpackage

//--- hdl/ccg_gain_ctrl.sv
// Purpose: Gain control and offset buffers of the current channel, and
//          source selection of the voltage and temperature measurement channels.
// Assumes: All inputs synchronous to sys_clk_i.
// Notes:   Amplifier magnitude is a 16-bit fraction of the reference.
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module ccg_gain_ctrl #(
    parameter int MAG_W = 16
) (
    // Clock and reset.
    input  wire logic              sys_clk_i,
    input  wire logic              sys_rst_i,
    // Register port.
    input  wire logic [3:0]        reg_addr_i,
    input  wire logic [7:0]        reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic      [15:0]       reg_rdata_o,
    // Analog front end.
    input  wire logic [MAG_W-1:0]  amp_mag_i,
    input  wire logic              shunt_missing_i,
    input  wire logic              conv_valid_i,
    input  wire logic [15:0]       cur_conv_i,
    input  wire logic [15:0]       vlt_conv_i,
    input  wire logic [15:0]       tmp_conv_i,
    output logic      [2:0]        active_gain_index_o,
    output logic                   shunt_sense_en_o,
    output logic                   aux_input_select_o,
    output logic                   external_temp_source_o,
    // Interrupt.
    output logic                   irq_o
);
    import ccg_pkg::*;

    logic [7:0]        gain_threshold_pair;
    logic [2:0]        active_gain_index;
    logic [3:0]        ctrl;
    logic [2:0]        status;
    logic [2:0]        mask;
    logic [7:0]        current_offset_comp [8];
    logic [15:0]       cur_res;
    logic [15:0]       vlt_res;
    logic [15:0]       tmp_res;
    ccg_state_type     state;
    logic [MAG_W+4:0]  up_lvl;
    logic [MAG_W+4:0]  dn_lvl;
    logic [MAG_W+4:0]  mag_x16;
    logic              hit_up;
    logic              hit_dn;
    logic              auto_step;
    logic [2:0]        next_gain;
    logic [2:0]        ev;
    logic              auto_gain_enable;

    assign auto_gain_enable = ctrl[CCG_CTRL_AUTO_BIT];

    // ---------------------------------------------------------------
    // Threshold decode
    // ---------------------------------------------------------------
    // Scale magnitude by 16 so thresholds compare as whole sixteenths.
    // An extra top bit keeps the full-reference level from wrapping to zero.
    assign mag_x16 = {1'b0, amp_mag_i, 4'h0};
    // Upper code n is (n+1)/16 of full scale.
    assign up_lvl = ({1'b0, gain_threshold_pair[7:4]} + 5'h01)
                    * (MAG_W+5)'(1 << MAG_W);
    // Lower code n is n/16 of full scale.
    assign dn_lvl = (MAG_W+5)'(gain_threshold_pair[3:0])
                    * (MAG_W+5)'(1 << MAG_W);
    assign hit_up = mag_x16 >= up_lvl;
    assign hit_dn = mag_x16 <= dn_lvl;

    // Step one notch per decision, clamped at both ends.
    always_comb begin
        next_gain = active_gain_index;
        auto_step = 1'b0;
        if (auto_gain_enable && state == CCG_IDLE) begin
            if (hit_up && active_gain_index != CCG_GAIN_MIN) begin
                next_gain = active_gain_index - 3'h1;
                auto_step = 1'b1;
            end else if (hit_dn && !hit_up
                         && active_gain_index != CCG_GAIN_MAX) begin
                next_gain = active_gain_index + 3'h1;
                auto_step = 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Gain engine
    // ---------------------------------------------------------------
    // One settle cycle after each step lets the amplifier output update.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= CCG_IDLE;
        end else begin
            case (state)
                CCG_IDLE: state <= auto_step ? CCG_HOLD : CCG_IDLE;
                CCG_HOLD: state <= CCG_IDLE;
                default:  state <= CCG_IDLE;
            endcase
        end
    end

    // Active gain: automatic step, or manual write while auto is off.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            active_gain_index <= CCG_GAIN_RST;
        end else if (auto_step) begin
            active_gain_index <= next_gain;
        end else if (reg_wr_i && reg_addr_i == CCG_REG_GAIN
                     && !auto_gain_enable) begin
            active_gain_index <= reg_wdata_i[2:0];
        end
    end
    assign active_gain_index_o = active_gain_index;

    // ---------------------------------------------------------------
    // Software registers
    // ---------------------------------------------------------------
    // Threshold pair, control bits and interrupt mask.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gain_threshold_pair <= CCG_THRESH_RST;
            ctrl                <= CCG_CTRL_RST;
            mask                <= 3'h0;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                CCG_REG_THRESH: gain_threshold_pair <= reg_wdata_i;
                CCG_REG_CTRL:   ctrl <= reg_wdata_i[3:0];
                CCG_REG_MASK:   mask <= reg_wdata_i[2:0];
                default:        ctrl <= ctrl;
            endcase
        end
    end
    assign shunt_sense_en_o       = ctrl[CCG_CTRL_SENSE_BIT];
    assign aux_input_select_o     = ctrl[CCG_CTRL_AUX_BIT];
    assign external_temp_source_o = ctrl[CCG_CTRL_ETMP_BIT];

    // Offset buffers, one per gain, reached through a single address.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_off
            always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    current_offset_comp[gi] <= 8'h00;
                end else if (reg_wr_i && reg_addr_i == CCG_REG_OFFSET
                             && active_gain_index == 3'(gi)) begin
                    current_offset_comp[gi] <= reg_wdata_i;
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // Results
    // ---------------------------------------------------------------
    // All three channels latch on the same strobe; the voltage register holds
    // whichever source is selected, temperature likewise.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cur_res <= 16'h0000;
            vlt_res <= 16'h0000;
            tmp_res <= 16'h0000;
        end else if (conv_valid_i) begin
            cur_res <= cur_conv_i;
            vlt_res <= vlt_conv_i;
            tmp_res <= tmp_conv_i;
        end
    end

    // ---------------------------------------------------------------
    // Status and interrupt
    // ---------------------------------------------------------------
    assign ev[CCG_ST_GAIN_BIT] = auto_step;
    assign ev[CCG_ST_OPEN_BIT] = shunt_missing_i
                                 && ctrl[CCG_CTRL_SENSE_BIT];
    assign ev[CCG_ST_RES_BIT]  = conv_valid_i;

    // Sticky bits; a new event wins over a write-one clear.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            status <= 3'h0;
        end else if (reg_wr_i && reg_addr_i == CCG_REG_STATUS) begin
            status <= (status & ~reg_wdata_i[2:0]) | ev;
        end else begin
            status <= status | ev;
        end
    end
    assign irq_o = |(status & mask);

    // Read data stands in the cycle after the strobe.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                CCG_REG_THRESH:  reg_rdata_o <= {8'h00, gain_threshold_pair};
                CCG_REG_GAIN:    reg_rdata_o <= {13'h0, active_gain_index};
                CCG_REG_CTRL:    reg_rdata_o <= {12'h000, ctrl};
                CCG_REG_STATUS:  reg_rdata_o <= {13'h0, status};
                CCG_REG_MASK:    reg_rdata_o <= {13'h0, mask};
                CCG_REG_OFFSET:  reg_rdata_o <= {8'h00,
                    current_offset_comp[active_gain_index]};
                CCG_REG_CUR_RES: reg_rdata_o <= cur_res;
                CCG_REG_VLT_RES: reg_rdata_o <= vlt_res;
                CCG_REG_TMP_RES: reg_rdata_o <= tmp_res;
                default:         reg_rdata_o <= 16'h0000;
            endcase
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    property p_step_one;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        auto_step |=> (active_gain_index == $past(next_gain));
    endproperty
    a_step_one: assert property (p_step_one)
        else $error("gain did not take one step");

    property p_up_down;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (auto_step && hit_up) |=>
            (active_gain_index + 3'h1 == $past(active_gain_index));
    endproperty
    a_up_down: assert property (p_up_down)
        else $error("upper threshold did not lower gain");

    property p_no_auto;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (!auto_gain_enable && !(reg_wr_i && reg_addr_i == CCG_REG_GAIN))
            |=> $stable(active_gain_index);
    endproperty
    a_no_auto: assert property (p_no_auto)
        else $error("gain moved with auto gain off");

    property p_manual;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (!auto_gain_enable && reg_wr_i && reg_addr_i == CCG_REG_GAIN)
            |=> active_gain_index == $past(reg_wdata_i[2:0]);
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual gain not applied");

    property p_flag;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        auto_step |=> status[CCG_ST_GAIN_BIT];
    endproperty
    a_flag: assert property (p_flag)
        else $error("gain changed flag not set");

    property p_read_gain;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (reg_rd_i && reg_addr_i == CCG_REG_GAIN) |=>
            reg_rdata_o[2:0] == $past(active_gain_index);
    endproperty
    a_read_gain: assert property (p_read_gain)
        else $error("gain readback wrong");

    property p_open;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        !ctrl[CCG_CTRL_SENSE_BIT] |-> !ev[CCG_ST_OPEN_BIT];
    endproperty
    a_open: assert property (p_open)
        else $error("open reported with sensing off");

    property p_sense;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        shunt_sense_en_o == ctrl[CCG_CTRL_SENSE_BIT];
    endproperty
    a_sense: assert property (p_sense)
        else $error("sense enable mismatch");

    property p_sync;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        conv_valid_i |=> (cur_res == $past(cur_conv_i))
                      && (vlt_res == $past(vlt_conv_i));
    endproperty
    a_sync: assert property (p_sync)
        else $error("channels not latched together");

    property p_step_up;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (auto_step && !hit_up) |=>
            (active_gain_index == $past(active_gain_index) + 3'h1);
    endproperty
    a_step_up: assert property (p_step_up)
        else $error("lower threshold did not raise gain");

    property p_sat_low;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (active_gain_index == CCG_GAIN_MIN && hit_up) |-> !auto_step;
    endproperty
    a_sat_low: assert property (p_sat_low)
        else $error("gain stepped below the lowest setting");

    property p_sat_high;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (active_gain_index == CCG_GAIN_MAX && !hit_up) |-> !auto_step;
    endproperty
    a_sat_high: assert property (p_sat_high)
        else $error("gain stepped above the highest setting");

    property p_hold;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (state == CCG_HOLD) |-> !auto_step;
    endproperty
    a_hold: assert property (p_hold)
        else $error("gain stepped during the settle cycle");

    property p_thr_top;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (gain_threshold_pair[7:4] == 4'hf) |-> !hit_up;
    endproperty
    a_thr_top: assert property (p_thr_top)
        else $error("full reference threshold reached below full scale");

    property p_thr_bot;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (gain_threshold_pair[3:0] == 4'h0 && amp_mag_i != '0) |-> !hit_dn;
    endproperty
    a_thr_bot: assert property (p_thr_bot)
        else $error("zero lower threshold reached above zero");

    property p_step_on_up;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (auto_gain_enable && state == CCG_IDLE && hit_up
         && active_gain_index != CCG_GAIN_MIN) |-> auto_step;
    endproperty
    a_step_on_up: assert property (p_step_on_up)
        else $error("upper threshold reached without a step");

    property p_step_on_dn;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (auto_gain_enable && state == CCG_IDLE && hit_dn && !hit_up
         && active_gain_index != CCG_GAIN_MAX) |-> auto_step;
    endproperty
    a_step_on_dn: assert property (p_step_on_dn)
        else $error("lower threshold reached without a step");

    property p_write_refused;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (auto_gain_enable && reg_wr_i && reg_addr_i == CCG_REG_GAIN
         && !auto_step) |=> $stable(active_gain_index);
    endproperty
    a_write_refused: assert property (p_write_refused)
        else $error("gain write taken with auto gain on");

    property p_flag_sticky;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (status[CCG_ST_GAIN_BIT] && !(reg_wr_i && reg_addr_i == CCG_REG_STATUS
         && reg_wdata_i[CCG_ST_GAIN_BIT])) |=> status[CCG_ST_GAIN_BIT];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("gain changed flag lost without a clear");

    property p_rd_zero;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        !reg_rd_i |=> (reg_rdata_o == 16'h0000);
    endproperty
    a_rd_zero: assert property (p_rd_zero)
        else $error("read data stood without a read");

    property p_off_read;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (reg_rd_i && reg_addr_i == CCG_REG_OFFSET) |=>
            (reg_rdata_o[7:0] == $past(current_offset_comp[active_gain_index]));
    endproperty
    a_off_read: assert property (p_off_read)
        else $error("offset read from the wrong buffer");
endmodule

//--- testbench/ccg_front_model.sv
// Purpose: Behavioural analog front end facing the gain control block.
// Assumes: The bench drives the analog controls on the rising edge.
// Notes:   Combinational, so it answers in the cycle it is asked.
`timescale 1ns/1ps
module ccg_front_model #(
    parameter logic [15:0] BAT_LVL = 16'h1234,
    parameter logic [15:0] AUX_LVL = 16'h5678,
    parameter logic [15:0] ITM_LVL = 16'h0111,
    parameter logic [15:0] ETM_LVL = 16'h0222
) (
    // Bench controls.
    input  wire logic [15:0] level_i,
    input  wire logic        open_i,
    input  wire logic        conv_req_i,
    input  wire logic [15:0] sh_hi_i,
    input  wire logic [15:0] sh_lo_i,
    // Block controls.
    input  wire logic        sense_en_i,
    input  wire logic        aux_sel_i,
    input  wire logic        etmp_sel_i,
    // Block inputs.
    output logic      [15:0] amp_mag_o,
    output logic             missing_o,
    output logic             valid_o,
    output logic      [15:0] cur_o,
    output logic      [15:0] vlt_o,
    output logic      [15:0] tmp_o
);
    // ------------------------------------------------------------
    // Analog behaviour
    // ------------------------------------------------------------
    // Magnitude follows the bench level; the detector needs sensing on.
    assign amp_mag_o = level_i;
    assign missing_o = open_i & sense_en_i;
    assign valid_o   = conv_req_i;
    // The drop is the low side minus the high side.
    assign cur_o = sh_lo_i - sh_hi_i;
    assign vlt_o = aux_sel_i ? AUX_LVL : BAT_LVL;
    assign tmp_o = etmp_sel_i ? ETM_LVL : ITM_LVL;
endmodule

//--- testbench/current_channel_gain_control_test.sv
// Purpose: Self-checking bench of the current channel gain control.
// Assumes: Source levels in the model are arbitrary markers.
// Notes:   Magnitude 4096 is one sixteenth of the reference.
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        miscompares++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module current_channel_gain_control_test;
    import ccg_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [15:0] BAT = 16'h1234, AUX = 16'h5678;
    localparam logic [15:0] ITM = 16'h0111, ETM = 16'h0222;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [15:0] rdata, rv, mag, cur, vlt, tmp;
    logic [15:0] level = 16'h8000, sh_hi = 16'h0000, sh_lo = 16'h0000;
    logic open_det = 1'b0, req = 1'b0, miss, vld, sen, aux, etm, irq;
    logic [2:0] gain;
    int miscompares = 0, tests_run = 0;
    always #5 clk = ~clk;
    ccg_front_model #(.BAT_LVL(BAT), .AUX_LVL(AUX), .ITM_LVL(ITM),
        .ETM_LVL(ETM)) u_model (.level_i(level), .open_i(open_det),
        .conv_req_i(req), .sh_hi_i(sh_hi), .sh_lo_i(sh_lo),
        .sense_en_i(sen), .aux_sel_i(aux), .etmp_sel_i(etm),
        .amp_mag_o(mag), .missing_o(miss), .valid_o(vld), .cur_o(cur),
        .vlt_o(vlt), .tmp_o(tmp));
    ccg_gain_ctrl u_dut (.sys_clk_i(clk), .sys_rst_i(rst),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .amp_mag_i(mag),
        .shunt_missing_i(miss), .conv_valid_i(vld), .cur_conv_i(cur),
        .vlt_conv_i(vlt), .tmp_conv_i(tmp), .active_gain_index_o(gain),
        .shunt_sense_en_o(sen), .aux_input_select_o(aux),
        .external_temp_source_o(etm), .irq_o(irq));
    // ------------------------------------------------------------
    // Bus and helper tasks
    // ------------------------------------------------------------
    // One-cycle write strobe.
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask
    task automatic set_lvl(input logic [15:0] v, input int n);
        @(posedge clk);
        level <= v;
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Bounded wait for the gain to reach a value.
    task automatic wait_gain(input logic [2:0] g);
        for (int i = 0; i < 40 && gain !== g; i++) @(posedge clk);
        #1 `CHK(gain, g)
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset;
        rd_reg(CCG_REG_THRESH);
        `CHK(rv, {8'h00, CCG_THRESH_RST})
        rd_reg(CCG_REG_CTRL);
        `CHK(rv, {12'h000, CCG_CTRL_RST})
        rd_reg(4'hf);
        `CHK(rv, 16'h0000)
        `CHK(gain, CCG_GAIN_RST)
        $display("test_reset done");
    endtask
    task automatic test_manual;
        wr_reg(CCG_REG_GAIN, 8'h05);
        set_lvl(16'h8000, 1);
        `CHK(gain, 3'h0)
        wr_reg(CCG_REG_CTRL, 8'h00);
        wr_reg(CCG_REG_GAIN, 8'h05);
        set_lvl(16'h0000, 10);
        `CHK(gain, 3'h5)
        rd_reg(CCG_REG_GAIN);
        `CHK(rv, 16'h0005)
        $display("test_manual done");
    endtask
    task automatic test_auto;
        wr_reg(CCG_REG_THRESH, 8'h73);
        wr_reg(CCG_REG_STATUS, 8'h07);
        // Level between the thresholds before auto gain comes on.
        set_lvl(16'h7fff, 0);
        wr_reg(CCG_REG_CTRL, 8'h01);
        set_lvl(16'h7fff, 8);
        `CHK(gain, 3'h5)
        set_lvl(16'h3001, 8);
        `CHK(gain, 3'h5)
        set_lvl(16'h8000, 0);
        for (int g = 4; g >= 0; g--) wait_gain(3'(g));
        set_lvl(16'h3000, 0);
        for (int g = 1; g < 8; g++) wait_gain(3'(g));
        set_lvl(16'h3000, 8);
        `CHK(gain, 3'h7)
        set_lvl(16'h5000, 2);
        rd_reg(CCG_REG_STATUS);
        `CHK(rv[CCG_ST_GAIN_BIT], 1'b1)
        wr_reg(CCG_REG_MASK, 8'h00);
        #1 `CHK(irq, 1'b0)
        wr_reg(CCG_REG_MASK, 8'h01);
        set_lvl(16'h5000, 1);
        `CHK(irq, 1'b1)
        wr_reg(CCG_REG_STATUS, 8'h01);
        set_lvl(16'h5000, 1);
        `CHK(irq, 1'b0)
        wr_reg(CCG_REG_THRESH, 8'hf0);
        set_lvl(16'hffff, 10);
        `CHK(gain, 3'h7)
        $display("test_auto done");
    endtask
    task automatic test_offset;
        wr_reg(CCG_REG_CTRL, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr_reg(CCG_REG_GAIN, 8'(i));
            wr_reg(CCG_REG_OFFSET, 8'(8'ha0 + i));
        end
        for (int i = 7; i >= 0; i--) begin
            wr_reg(CCG_REG_GAIN, 8'(i));
            rd_reg(CCG_REG_OFFSET);
            `CHK(rv, 16'(8'ha0 + i))
        end
        $display("test_offset done");
    endtask
    task automatic test_shunt;
        open_det <= 1'b1;
        rd_reg(CCG_REG_STATUS);
        `CHK({sen, rv[CCG_ST_OPEN_BIT]}, 2'b00)
        wr_reg(CCG_REG_CTRL, 8'h02);
        rd_reg(CCG_REG_STATUS);
        `CHK({sen, rv[CCG_ST_OPEN_BIT]}, 2'b11)
        open_det <= 1'b0;
        wr_reg(CCG_REG_STATUS, 8'h02);
        $display("test_shunt done");
    endtask
    task automatic test_results;
        logic [15:0] ec;
        for (int s = 0; s < 4; s++) begin
            wr_reg(CCG_REG_CTRL, 8'(s << 2));
            sh_hi <= 16'h0100;
            sh_lo <= s[0] ? 16'h0040 : 16'h0300;
            ec = s[0] ? 16'hff40 : 16'h0200;
            req <= 1'b1;
            @(posedge clk);
            req <= 1'b0;
            rd_reg(CCG_REG_CUR_RES);
            `CHK(rv, ec)
            rd_reg(CCG_REG_VLT_RES);
            `CHK(rv, s[0] ? AUX : BAT)
            rd_reg(CCG_REG_TMP_RES);
            `CHK(rv, s[1] ? ETM : ITM)
            rd_reg(CCG_REG_STATUS);
            `CHK({aux, rv[CCG_ST_RES_BIT]}, {s[0], 1'b1})
            wr_reg(CCG_REG_STATUS, 8'h04);
        end
        $display("test_results done");
    endtask
    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main sequence after five cycles of reset.
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        test_reset;
        test_manual;
        test_auto;
        test_offset;
        test_shunt;
        test_results;
        final_report;
    end
    // Watchdog, well beyond the expected few hundred cycles.
    initial begin
        #200000;
        miscompares++;
        final_report;
    end
endmodule
